// [core/prs_pkg.sv]
/*
  Constants for the peripheral register spaces: space sizes, indexes of the
  setup, output and input registers, and load command codes.
  Assumes an 8-bit core data path.
*/
package prs_pkg;

  localparam int DATA_W    = 8;
  localparam int SETUP_NUM = 21;
  localparam int OUT_NUM   = 10;
  localparam int IN_NUM    = 20;
  localparam int IDX_W     = 5;

  // Setup space indexes.
  localparam logic [4:0] CFG_IRQ_MASK    = 5'h00;
  localparam logic [4:0] CFG_CMP_ONE     = 5'h01;
  localparam logic [4:0] CFG_WATCHDOG    = 5'h02;
  localparam logic [4:0] CFG_CMP_TWO     = 5'h03;
  localparam logic [4:0] CFG_BANK0_DIR   = 5'h04;
  localparam logic [4:0] CFG_TMR_MODE    = 5'h05;
  localparam logic [4:0] CFG_TMR_WAVE    = 5'h06;
  localparam logic [4:0] CFG_TMR_PRESC   = 5'h07;
  localparam logic [4:0] CFG_PHS_PRESC   = 5'h08;
  localparam logic [4:0] CFG_PHS_WAVE    = 5'h09;
  localparam logic [4:0] CFG_PHS_MODE    = 5'h0a;
  localparam logic [4:0] CFG_BANK2_DIR   = 5'h0b;
  localparam logic [4:0] CFG_BANK0_ALT   = 5'h0c;
  localparam logic [4:0] CFG_BANK1_DIR   = 5'h0d;
  localparam logic [4:0] CFG_BANK1_ANA   = 5'h0e;
  localparam logic [4:0] CFG_CMP_PRESC   = 5'h0f;
  localparam logic [4:0] CFG_CMP_CONV    = 5'h10;
  localparam logic [4:0] CFG_IRQ_PRIO1   = 5'h11;
  localparam logic [4:0] CFG_IRQ_PRIO2   = 5'h12;
  localparam logic [4:0] CFG_PHS_WIDTH1  = 5'h13;
  localparam logic [4:0] CFG_PHS_WIDTH2  = 5'h14;

  // Output space addresses.
  localparam logic [4:0] OUT_BANK0       = 5'h00;
  localparam logic [4:0] OUT_BANK1       = 5'h01;
  localparam logic [4:0] OUT_BANK2       = 5'h02;
  localparam logic [4:0] OUT_TMR_COUNT   = 5'h03;
  localparam logic [4:0] OUT_TMR_RELOAD  = 5'h04;
  localparam logic [4:0] OUT_PHS_COUNT   = 5'h09;

  // Input space addresses.
  localparam logic [4:0] IN_STACK        = 5'h00;
  localparam logic [4:0] IN_CMP_FIRST    = 5'h01;
  localparam logic [4:0] IN_CMP_LAST     = 5'h0c;
  localparam logic [4:0] IN_CMP_STATE    = 5'h0d;
  localparam logic [4:0] IN_BANK0        = 5'h0e;
  localparam logic [4:0] IN_BANK1        = 5'h0f;
  localparam logic [4:0] IN_BANK2        = 5'h10;
  localparam logic [4:0] IN_PHS_COUNT    = 5'h11;
  localparam logic [4:0] IN_TMR_COUNT    = 5'h12;
  localparam logic [4:0] IN_TMR_STATE    = 5'h13;

  // Load command codes presented by the control unit.
  localparam logic [2:0] OP_NONE         = 3'h0;
  localparam logic [2:0] OP_SETUP_PROG   = 3'h1;
  localparam logic [2:0] OP_SETUP_RAM    = 3'h2;
  localparam logic [2:0] OP_OUT_PROG     = 3'h3;
  localparam logic [2:0] OP_OUT_RAM      = 3'h4;
  localparam logic [2:0] OP_IN_COPY      = 3'h5;

  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam logic [7:0] TMR_MODE_PWM    = 8'h01;

endpackage

// [core/prs_setup_mem.sv]
/*
  Small register memory for the setup space: one write port, a registered
  read port and every word visible as a flat vector for the peripherals.
  Assumes writes come from the main decode on the same clock.
*/
`timescale 1ns/1ns
module prs_setup_mem #(
  parameter int DEPTH = 21,
  parameter int WIDTH = 8,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Write port
  input  wire logic                   wr_en,
  input  wire logic [AW-1:0]          wr_idx,
  input  wire logic [WIDTH-1:0]       wr_data,
  // Read port
  input  wire logic [AW-1:0]          rd_idx,
  output logic      [WIDTH-1:0]       rd_data,
  // Every word
  output logic      [DEPTH*WIDTH-1:0] words
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_word
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mem_reg[g] <= prs_pkg::RESET_VALUE;
        else if (wr_en && wr_idx == AW'(g))
          mem_reg[g] <= wr_data;
      end
      assign words[g*WIDTH +: WIDTH] = mem_reg[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= prs_pkg::RESET_VALUE;
    else if (int'(rd_idx) < DEPTH)
      rd_data <= mem_reg[rd_idx];
    else
      rd_data <= prs_pkg::RESET_VALUE;
  end

endmodule

// [core/prs_regspaces.sv]
/*
  Setup, output and input register spaces of the controller core. The
  control unit presents one load command per cycle with an index and the
  byte already fetched from program memory or RAM.
  Assumes the control unit has applied the current page to program fetches
  and holds the peripheral values on the same clock.
*/
`timescale 1ns/1ns
// Overview of operation
// R01 - A program-memory setup load writes the fetched byte to the selected setup register.
// R02 - A RAM setup load writes the RAM byte to the selected setup register.
// R03 - The setup space holds 21 registers, each for one peripheral function.
// R04 - Index 0 holds interrupt mask and polarity; 17 and 18 hold priorities.
// R05 - Timer mode at 5, waveform at 6, prescaler at 7.
// R06 - Phase driver prescaler 8, waveform 9, mode 10, pulse width 19 and 20.
// R07 - Port setup: 4, 12, 13, 14 and 11 as listed.
// R08 - Comparator at 1, 3, 15, 16; watchdog at 2.
// R09 - Output space has 6 registers at plain decimal addresses.
// R10 - A program-memory output load writes the fetched byte to the output register.
// R11 - A RAM output load writes the RAM byte to the output register.
// R12 - Outputs 0 to 2 ports, 3 timer count, 9 phase count, 5 to 8 unused.
// R13 - Output 4 is the timer reload, used only in pulse-width mode.
// R14 - Inputs: 0 stack, 14 to 16 ports, 17 phase, 18 timer, 19 status.
// R15 - Inputs 1 to 12 give six channel results high then low; 13 comparator state.
// R16 - The input space has 20 byte registers copied to RAM by a load.
// R17 - Writes to unused or absent registers are ignored; unused inputs read zero.
// R18 - Input reads have no side effect; loads take effect the next cycle. Here TMR_RELOAD takes effect one cycle after that.
module prs_regspaces #(
  parameter bit HAS_CMP   = 1'b1,
  parameter bit HAS_BANK2 = 1'b1
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // Load command from the control unit
  input  wire logic [2:0]  LOAD_OP,
  input  wire logic [4:0]  LOAD_IDX,
  input  wire logic [7:0]  LOAD_DATA,
  // Input space copy result
  output logic      [7:0]  COPY_DATA,
  output logic             COPY_VALID,
  // Values gathered from peripherals
  input  wire logic [7:0]  STACK_INDEX,
  input  wire logic [95:0] CMP_RESULTS,
  input  wire logic [7:0]  CMP_STATE,
  input  wire logic [7:0]  BANK0_IN,
  input  wire logic [7:0]  BANK1_IN,
  input  wire logic [7:0]  BANK2_IN,
  input  wire logic [7:0]  PHS_COUNT_IN,
  input  wire logic [7:0]  TMR_COUNT_IN,
  input  wire logic [7:0]  TMR_STATE,
  // Output space toward peripherals
  output logic      [7:0]  BANK0_OUT,
  output logic      [7:0]  BANK1_OUT,
  output logic      [7:0]  BANK2_OUT,
  output logic      [7:0]  TMR_COUNT_LOAD,
  output logic             TMR_COUNT_WR,
  output logic      [7:0]  TMR_RELOAD,
  output logic      [7:0]  PHS_COUNT_LOAD,
  output logic             PHS_COUNT_WR,
  // Setup space toward peripherals
  output logic      [167:0] SETUP_WORDS
);

  localparam int W = prs_pkg::DATA_W;

  // Returns high for setup indexes that exist on this variant.
  function automatic logic setup_present(input logic [4:0] idx);
    logic cmp_idx;
    cmp_idx = idx == prs_pkg::CFG_CMP_ONE || idx == prs_pkg::CFG_CMP_TWO ||
              idx == prs_pkg::CFG_BANK1_ANA || idx == prs_pkg::CFG_CMP_PRESC ||
              idx == prs_pkg::CFG_CMP_CONV;
    return (int'(idx) < prs_pkg::SETUP_NUM) && (HAS_CMP || !cmp_idx);
  endfunction

  // Returns high for output addresses that are mapped on this variant.
  function automatic logic out_present(input logic [4:0] idx);
    logic known;
    known = idx == prs_pkg::OUT_BANK0 || idx == prs_pkg::OUT_BANK1 ||
            idx == prs_pkg::OUT_TMR_COUNT || idx == prs_pkg::OUT_TMR_RELOAD ||
            idx == prs_pkg::OUT_PHS_COUNT ||
            (idx == prs_pkg::OUT_BANK2 && HAS_BANK2);
    return known;
  endfunction

  wire logic setup_load = LOAD_OP == prs_pkg::OP_SETUP_PROG || // R01
                          LOAD_OP == prs_pkg::OP_SETUP_RAM;    // R02
  wire logic out_load   = LOAD_OP == prs_pkg::OP_OUT_PROG ||   // R10
                          LOAD_OP == prs_pkg::OP_OUT_RAM;      // R11
  wire logic in_copy    = LOAD_OP == prs_pkg::OP_IN_COPY;

  wire logic setup_wr = setup_load && setup_present(LOAD_IDX); // R17
  wire logic out_wr   = out_load && out_present(LOAD_IDX);     // R17

  // The setup words live in a memory; peripherals see every word at once.
  prs_setup_mem #(
    .DEPTH (prs_pkg::SETUP_NUM),
    .WIDTH (W),
    .AW    (prs_pkg::IDX_W)
  ) u_setup (
    .clk     (CORE_CLK),
    .rst_n   (RSTN),
    .wr_en   (setup_wr),  // R03
    .wr_idx  (LOAD_IDX),
    .wr_data (LOAD_DATA),
    .rd_idx  (LOAD_IDX),
    .rd_data (),
    .words   (SETUP_WORDS) // R04 R05 R06 R07 R08
  );

  // Output space decode.
  wire logic wr_bank0  = out_wr && LOAD_IDX == prs_pkg::OUT_BANK0;      // R12
  wire logic wr_bank1  = out_wr && LOAD_IDX == prs_pkg::OUT_BANK1;      // R09
  wire logic wr_bank2  = out_wr && LOAD_IDX == prs_pkg::OUT_BANK2;      // R12
  wire logic wr_tcount = out_wr && LOAD_IDX == prs_pkg::OUT_TMR_COUNT;  // R12
  wire logic wr_reload = out_wr && LOAD_IDX == prs_pkg::OUT_TMR_RELOAD; // R13
  wire logic wr_pcount = out_wr && LOAD_IDX == prs_pkg::OUT_PHS_COUNT;  // R12

  // The timer only honours the reload byte in pulse-width mode, so the
  // register is written always but gated toward the timer.
  logic [7:0] reload_reg;
  wire logic  tmr_pwm = SETUP_WORDS[prs_pkg::CFG_TMR_MODE*W +: W] == prs_pkg::TMR_MODE_PWM;
  wire logic [7:0] reload_next = tmr_pwm ? reload_reg : prs_pkg::RESET_VALUE; // R13

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      BANK0_OUT      <= prs_pkg::RESET_VALUE;
      BANK1_OUT      <= prs_pkg::RESET_VALUE;
      BANK2_OUT      <= prs_pkg::RESET_VALUE;
      TMR_COUNT_LOAD <= prs_pkg::RESET_VALUE;
      PHS_COUNT_LOAD <= prs_pkg::RESET_VALUE;
      reload_reg     <= prs_pkg::RESET_VALUE;
      TMR_COUNT_WR   <= 1'b0;
      PHS_COUNT_WR   <= 1'b0;
    end
    else
    begin
      if (wr_bank0)
        BANK0_OUT <= LOAD_DATA; // R18
      if (wr_bank1)
        BANK1_OUT <= LOAD_DATA;
      if (wr_bank2)
        BANK2_OUT <= LOAD_DATA;
      if (wr_tcount)
        TMR_COUNT_LOAD <= LOAD_DATA;
      if (wr_pcount)
        PHS_COUNT_LOAD <= LOAD_DATA;
      if (wr_reload)
        reload_reg <= LOAD_DATA;
      TMR_COUNT_WR <= wr_tcount;
      PHS_COUNT_WR <= wr_pcount;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      TMR_RELOAD <= prs_pkg::RESET_VALUE;
    else
      TMR_RELOAD <= reload_next;
  end

  // Input space select. Reading is a plain mux, so peripherals never see it.
  wire logic [4:0] cmp_off = LOAD_IDX - prs_pkg::IN_CMP_FIRST;
  wire logic       cmp_sel = LOAD_IDX >= prs_pkg::IN_CMP_FIRST &&
                             LOAD_IDX <= prs_pkg::IN_CMP_LAST;
  // Channel n high byte sits at CMP_RESULTS[16n+15:16n+8], low byte below it.
  wire logic [3:0] cmp_ch  = 4'(cmp_off >> 1);
  wire logic       cmp_lo  = cmp_off[0];
  wire logic [7:0] cmp_byte = CMP_RESULTS[(int'(cmp_ch)*16 + (cmp_lo ? 0 : 8)) +: 8]; // R15

  logic [7:0] in_mux;
  always_comb
  begin
    in_mux = prs_pkg::RESET_VALUE; // R17
    if (cmp_sel && HAS_CMP)
      in_mux = cmp_byte;
    else
      case (LOAD_IDX)
        prs_pkg::IN_STACK:     in_mux = STACK_INDEX; // R14
        prs_pkg::IN_CMP_STATE: in_mux = HAS_CMP ? CMP_STATE : prs_pkg::RESET_VALUE; // R15
        prs_pkg::IN_BANK0:     in_mux = BANK0_IN;
        prs_pkg::IN_BANK1:     in_mux = BANK1_IN;
        prs_pkg::IN_BANK2:     in_mux = HAS_BANK2 ? BANK2_IN : prs_pkg::RESET_VALUE;
        prs_pkg::IN_PHS_COUNT: in_mux = PHS_COUNT_IN;
        prs_pkg::IN_TMR_COUNT: in_mux = TMR_COUNT_IN;
        prs_pkg::IN_TMR_STATE: in_mux = TMR_STATE;
        default:               in_mux = prs_pkg::RESET_VALUE; // R16
      endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      COPY_DATA  <= prs_pkg::RESET_VALUE;
      COPY_VALID <= 1'b0;
    end
    else
    begin
      COPY_VALID <= in_copy; // R16
      if (in_copy)
        COPY_DATA <= in_mux;
    end
  end

  // Checks.
  chk_setup_load: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R01
    setup_load && LOAD_IDX == prs_pkg::CFG_TMR_MODE
    |=> SETUP_WORDS[prs_pkg::CFG_TMR_MODE*W +: W] == $past(LOAD_DATA))
    else $error("setup load not stored");
  chk_setup_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R03
    !setup_load |=> $stable(SETUP_WORDS))
    else $error("setup words changed without a load");
  chk_bank0_write: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R12
    out_load && LOAD_IDX == prs_pkg::OUT_BANK0 |=> BANK0_OUT == $past(LOAD_DATA))
    else $error("bank0 output not written");
  chk_unused_out: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R17
    out_load && LOAD_IDX >= 5'h05 && LOAD_IDX <= 5'h08
    |=> $stable(BANK0_OUT) && $stable(BANK1_OUT) && !TMR_COUNT_WR && !PHS_COUNT_WR)
    else $error("unused output address changed state");
  chk_count_strobe: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R18
    out_load && LOAD_IDX == prs_pkg::OUT_TMR_COUNT
    |=> TMR_COUNT_WR ##1 !TMR_COUNT_WR || $past(out_load && LOAD_IDX == prs_pkg::OUT_TMR_COUNT))
    else $error("timer count strobe wrong");
  chk_reload_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R13
    !tmr_pwm |=> TMR_RELOAD == 8'h00)
    else $error("reload passed outside pulse-width mode");
  chk_copy_stack: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R14
    in_copy && LOAD_IDX == prs_pkg::IN_STACK |=> COPY_VALID && COPY_DATA == $past(STACK_INDEX))
    else $error("stack index copy wrong");
  chk_copy_unused: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R17
    in_copy && LOAD_IDX > prs_pkg::IN_TMR_STATE |=> COPY_DATA == 8'h00)
    else $error("unused input did not read zero");
  chk_copy_cmp: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R15
    in_copy && LOAD_IDX == prs_pkg::IN_CMP_FIRST && HAS_CMP
    |=> COPY_DATA == $past(CMP_RESULTS[15:8]))
    else $error("channel 0 high byte wrong");
  chk_bank1_write: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R09
    out_load && LOAD_IDX == prs_pkg::OUT_BANK1 |=> BANK1_OUT == $past(LOAD_DATA))
    else $error("bank1 output not written");
  chk_bank2_write: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R12
    out_load && LOAD_IDX == prs_pkg::OUT_BANK2 && HAS_BANK2 |=> BANK2_OUT == $past(LOAD_DATA))
    else $error("bank2 output not written");
  chk_bank2_absent: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R17
    out_load && LOAD_IDX == prs_pkg::OUT_BANK2 && !HAS_BANK2 |=> $stable(BANK2_OUT))
    else $error("absent bank2 output written");
  chk_phs_strobe: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R12
    out_load && LOAD_IDX == prs_pkg::OUT_PHS_COUNT
    |=> PHS_COUNT_WR && PHS_COUNT_LOAD == $past(LOAD_DATA))
    else $error("phase count load wrong");
  chk_reload_pass: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R13
    tmr_pwm && wr_reload ##1 tmr_pwm |=> TMR_RELOAD == $past(LOAD_DATA, 2))
    else $error("reload not passed in pulse-width mode");
  chk_setup_ignore: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R17
    setup_load && !setup_wr |=> $stable(SETUP_WORDS))
    else $error("absent setup index written");
  chk_copy_pulse: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R16
    !in_copy |=> !COPY_VALID)
    else $error("copy valid without a copy");
  chk_copy_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R18
    !in_copy |=> $stable(COPY_DATA))
    else $error("copy data changed without a copy");
  chk_copy_state: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R15
    in_copy && LOAD_IDX == prs_pkg::IN_CMP_STATE
    |=> COPY_DATA == (HAS_CMP ? $past(CMP_STATE) : 8'h00))
    else $error("comparator state copy wrong");
  chk_copy_bank2: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // R14
    in_copy && LOAD_IDX == prs_pkg::IN_BANK2
    |=> COPY_DATA == (HAS_BANK2 ? $past(BANK2_IN) : 8'h00))
    else $error("bank2 input copy wrong");

endmodule

// [dv/prs_cu_model.sv]
/*
  Control unit model: presents one load command at a time to the register
  spaces, with the operand byte already fetched from program memory or RAM.
  Assumes the register spaces sample the command on the rising clock edge.
*/
`timescale 1ns/1ns
module prs_cu_model (
  // Clock
  input  wire logic       clk,
  // Load command toward the register spaces
  output logic      [2:0] op,
  output logic      [4:0] idx,
  output logic      [7:0] data
);
  initial
  begin
    op   = prs_pkg::OP_NONE;
    idx  = 5'h00;
    data = 8'h00;
  end

  task automatic issue(input logic [2:0] c, input logic [4:0] i, input logic [7:0] d);
    @(negedge clk);
    op   = c;
    idx  = i;
    data = d;
    @(negedge clk);
    // Released operands are inverted so that a late sample is caught.
    op   = prs_pkg::OP_NONE;
    idx  = ~i;
    data = ~d;
  endtask
endmodule

// [dv/tb_peripheral_register_spaces.sv]
/*
  Self-checking bench for the peripheral register spaces.
  Checks the default variant, with comparator and third port present, and a reduced variant without them.
*/
`timescale 1ns/1ns
module tb_peripheral_register_spaces;
  typedef struct packed {logic [2:0] op; logic [4:0] idx; logic [7:0] data;} prs_tb_row_t;
  logic          CORE_CLK = 1'b0;
  logic          RSTN     = 1'b0;
  logic [7:0]    STACK_INDEX = 8'ha1, CMP_STATE = 8'hb2, BANK0_IN = 8'hc3, BANK1_IN = 8'hd4;
  logic [7:0]    BANK2_IN = 8'he5, PHS_COUNT_IN = 8'hf6, TMR_COUNT_IN = 8'h17, TMR_STATE = 8'h28;
  logic [95:0]   CMP_RESULTS = 96'h0102_0304_0506_0708_090a_0b0c;
  logic [2:0]    LOAD_OP;
  logic [4:0]    LOAD_IDX;
  logic [7:0]    LOAD_DATA, COPY_DATA, BANK0_OUT, BANK1_OUT, BANK2_OUT;
  logic [7:0]    TMR_COUNT_LOAD, TMR_RELOAD, PHS_COUNT_LOAD;
  logic          COPY_VALID, TMR_COUNT_WR, PHS_COUNT_WR;
  logic [167:0]  SETUP_WORDS, exp_setup;
  logic [7:0]    exp_b [3];
  logic [167:0]  v_setup, exp_setup_v;
  logic [7:0]    v_bank2, v_copy;
  int            err_count = 0;
  int            compares  = 0;
  prs_tb_row_t   rows [6] = '{{3'h1, 5'h00, 8'h11}, {3'h2, 5'h14, 8'h22}, {3'h3, 5'h00, 8'h33},
                              {3'h4, 5'h01, 8'h44}, {3'h3, 5'h02, 8'h55}, {3'h2, 5'h15, 8'h66}};

  initial
  begin
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  prs_cu_model i_cu (.clk(CORE_CLK), .op(LOAD_OP), .idx(LOAD_IDX), .data(LOAD_DATA));

  prs_regspaces i_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .LOAD_OP(LOAD_OP), .LOAD_IDX(LOAD_IDX),
    .LOAD_DATA(LOAD_DATA), .COPY_DATA(COPY_DATA), .COPY_VALID(COPY_VALID),
    .STACK_INDEX(STACK_INDEX), .CMP_RESULTS(CMP_RESULTS), .CMP_STATE(CMP_STATE),
    .BANK0_IN(BANK0_IN), .BANK1_IN(BANK1_IN), .BANK2_IN(BANK2_IN), .PHS_COUNT_IN(PHS_COUNT_IN),
    .TMR_COUNT_IN(TMR_COUNT_IN), .TMR_STATE(TMR_STATE), .BANK0_OUT(BANK0_OUT),
    .BANK1_OUT(BANK1_OUT), .BANK2_OUT(BANK2_OUT), .TMR_COUNT_LOAD(TMR_COUNT_LOAD),
    .TMR_COUNT_WR(TMR_COUNT_WR), .TMR_RELOAD(TMR_RELOAD), .PHS_COUNT_LOAD(PHS_COUNT_LOAD),
    .PHS_COUNT_WR(PHS_COUNT_WR), .SETUP_WORDS(SETUP_WORDS));

  // Reduced variant with no comparator and no third port, so the ignored paths get exercised.
  prs_regspaces #(.HAS_CMP(1'b0), .HAS_BANK2(1'b0)) i_dut_var (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .LOAD_OP(LOAD_OP), .LOAD_IDX(LOAD_IDX), .LOAD_DATA(LOAD_DATA), .COPY_DATA(v_copy),
    .COPY_VALID(), .STACK_INDEX(STACK_INDEX), .CMP_RESULTS(CMP_RESULTS), .CMP_STATE(CMP_STATE),
    .BANK0_IN(BANK0_IN), .BANK1_IN(BANK1_IN), .BANK2_IN(BANK2_IN), .PHS_COUNT_IN(PHS_COUNT_IN),
    .TMR_COUNT_IN(TMR_COUNT_IN), .TMR_STATE(TMR_STATE), .BANK0_OUT(), .BANK1_OUT(),
    .BANK2_OUT(v_bank2), .TMR_COUNT_LOAD(), .TMR_COUNT_WR(), .TMR_RELOAD(),
    .PHS_COUNT_LOAD(), .PHS_COUNT_WR(), .SETUP_WORDS(v_setup));

  task automatic check(input logic [199:0] seen, input logic [199:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Reference copy of what each load should leave behind.
  task automatic upd(input logic [2:0] op, input logic [4:0] idx, input logic [7:0] d);
    if ((op == prs_pkg::OP_SETUP_PROG || op == prs_pkg::OP_SETUP_RAM) && idx < 21)
      exp_setup[8*idx +: 8] = d;
    if ((op == prs_pkg::OP_SETUP_PROG || op == prs_pkg::OP_SETUP_RAM) && idx < 21 &&
        !(idx inside {5'd1, 5'd3, 5'd14, 5'd15, 5'd16}))
      exp_setup_v[8*idx +: 8] = d;
    if ((op == prs_pkg::OP_OUT_PROG || op == prs_pkg::OP_OUT_RAM) && idx < 3)
      exp_b[idx] = d;
  endtask

  task automatic load(input logic [2:0] op, input logic [4:0] idx, input logic [7:0] d);
    i_cu.issue(op, idx, d);
    upd(op, idx, d);
  endtask

  function automatic logic [7:0] exp_in(input int a);
    case (a)
      0:  return STACK_INDEX;
      13: return CMP_STATE;
      14: return BANK0_IN;
      15: return BANK1_IN;
      16: return BANK2_IN;
      17: return PHS_COUNT_IN;
      18: return TMR_COUNT_IN;
      19: return TMR_STATE;
      default: if (a >= 1 && a <= 12)
        return a % 2 ? CMP_RESULTS[16*((a-1)/2)+8 +: 8] : CMP_RESULTS[16*((a-2)/2) +: 8];
    endcase
    return 8'h00;
  endfunction

  task automatic check_all_zero();
    check({SETUP_WORDS, BANK0_OUT, BANK1_OUT, BANK2_OUT, TMR_RELOAD}, 200'h0);
    check({COPY_VALID, TMR_COUNT_WR, PHS_COUNT_WR, COPY_DATA, TMR_COUNT_LOAD, PHS_COUNT_LOAD},
          27'h0);
    check({v_setup, v_bank2, v_copy}, 184'h0);
  endtask

  task automatic stop_test();
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end

  initial
  begin
    exp_setup = '0;
    exp_setup_v = '0;
    exp_b = '{8'h00, 8'h00, 8'h00};
    repeat (20) @(negedge CORE_CLK);
    check_all_zero();
    RSTN = 1'b1;
    $display("Test reset done");
    foreach (rows[r])
    begin
      load(rows[r].op, rows[r].idx, rows[r].data);
      check(SETUP_WORDS, exp_setup);
      check(v_setup, exp_setup_v);
      check({BANK0_OUT, BANK1_OUT, BANK2_OUT}, {exp_b[0], exp_b[1], exp_b[2]});
    end
    $display("Test table done");
    for (int i = 0; i < 32; i++)
    begin
      load(i % 2 ? prs_pkg::OP_SETUP_RAM : prs_pkg::OP_SETUP_PROG, 5'(i), 8'(8'h40 + i));
      check(SETUP_WORDS, exp_setup);
      check(v_setup, exp_setup_v);
    end
    $display("Test setup sweep done");
    for (int a = 0; a < 11; a++)
    begin
      load(a % 2 ? prs_pkg::OP_OUT_RAM : prs_pkg::OP_OUT_PROG, 5'(a), 8'(8'h80 + a));
      check({BANK0_OUT, BANK1_OUT, BANK2_OUT}, {exp_b[0], exp_b[1], exp_b[2]});
      check({TMR_COUNT_WR, PHS_COUNT_WR}, {a == 3, a == 9});
      check(v_bank2, 8'h00);
      if (a == 3)
        check(TMR_COUNT_LOAD, 8'h83);
      if (a == 9)
        check(PHS_COUNT_LOAD, 8'h89);
      @(negedge CORE_CLK);
      check({TMR_COUNT_WR, PHS_COUNT_WR}, 2'h0);
    end
    $display("Test output sweep done");
    // The reload byte is already held; only the timer mode decides if it shows.
    check(TMR_RELOAD, 8'h00);
    load(prs_pkg::OP_SETUP_PROG, prs_pkg::CFG_TMR_MODE, prs_pkg::TMR_MODE_PWM);
    @(negedge CORE_CLK);
    check(TMR_RELOAD, 8'h84);
    load(prs_pkg::OP_OUT_PROG, prs_pkg::OUT_TMR_RELOAD, 8'h9c);
    @(negedge CORE_CLK);
    check(TMR_RELOAD, 8'h9c);
    load(prs_pkg::OP_SETUP_RAM, prs_pkg::CFG_TMR_MODE, 8'h00);
    @(negedge CORE_CLK);
    check(TMR_RELOAD, 8'h00);
    $display("Test reload done");
    for (int a = 0; a < 22; a++)
    begin
      load(prs_pkg::OP_IN_COPY, 5'(a), 8'h00);
      check({COPY_VALID, COPY_DATA}, {1'b1, exp_in(a)});
      check(v_copy, (a >= 1 && a <= 13) || a == 16 ? 8'h00 : exp_in(a));
      @(negedge CORE_CLK);
      check({COPY_VALID, COPY_DATA}, {1'b0, exp_in(a)});
    end
    check(SETUP_WORDS, exp_setup);
    $display("Test input copy done");
    @(negedge CORE_CLK);
    RSTN = 1'b0;
    @(negedge CORE_CLK);
    check_all_zero();
    RSTN = 1'b1;
    exp_setup = '0;
    exp_setup_v = '0;
    exp_b = '{8'h00, 8'h00, 8'h00};
    load(prs_pkg::OP_OUT_RAM, prs_pkg::OUT_BANK1, 8'h5a);
    check({BANK0_OUT, BANK1_OUT, BANK2_OUT}, {8'h00, 8'h5a, 8'h00});
    $display("Test mid reset done");
    stop_test();
  end
endmodule
